// ### design/dma_slave_pkg.sv
// Constants shared by the distributed DMA slave register block.
package dma_slave_pkg;
	// Configuration-space location of the DMA window base register.
	localparam logic [7:0]  CFG_BASE_OFF   = 8'h98;
	// Reset value: bit 0 marks the base as an I/O space base.
	localparam logic [31:0] CFG_BASE_RST   = 32'h0000_0001;
	localparam int          WIN_BITS       = 4;
	localparam int          WINDOW_BYTES   = 16;
	// Word offsets inside the 16-byte window.
	localparam logic [3:0]  OFF_ADDR       = 4'h0;
	localparam logic [3:0]  OFF_COUNT      = 4'h4;
	localparam logic [3:0]  OFF_STAT       = 4'h8;
	localparam logic [3:0]  OFF_MASK       = 4'hC;
	localparam logic [3:0]  OFF_WORD_MASK  = 4'hC;
	// Command byte fields.
	localparam logic [7:0]  CMD_LIVE_MASK  = 8'hFC;
	localparam int          CMD_DISABLE    = 2;
	// Request byte fields.
	localparam int          REQ_BIT        = 2;
	// Mode byte fields.
	localparam int          MODE_AUTO      = 4;
	localparam int          MODE_DEC       = 5;
	// Status byte fields.
	localparam int          STAT_TC        = 0;
	localparam int          STAT_REQ       = 4;
	// Multichannel mask field.
	localparam int          MASK_BIT       = 0;
	// Reset values of the channel state.
	localparam logic [7:0]  CMD_RST        = 8'h00;
	localparam logic [7:0]  MODE_RST       = 8'h00;
	localparam logic [15:0] WORD16_RST     = 16'h0000;
	localparam logic [7:0]  BYTE_RST       = 8'h00;
endpackage : dma_slave_pkg

// ### design/dma_slave_regs.sv
// Distributed DMA slave channel registers with configuration base and I/O window decode.
//
// Overview of operation
// [R01] A window base register at configuration offset 98h tells the host where the DMA registers live.
// [R02] A 16-byte block of I/O space starting at the programmed base is claimed as the DMA register set.
// [R03] Each register works like the same-named register of the classic legacy DMA controller.
// [R04] Legacy bits that mean nothing for distributed DMA are read-only and have no effect when written.
// [R05] Reserved locations in the window read back as all zeros.
// [R06] Writes to reserved locations are dropped and change no state.
// [R07] Offset 00h reads current address and page and writes the base address, with the top byte reserved.
// [R08] Offset 04h reads the remaining word count and writes the base count, with the upper bytes reserved.
// [R09] Offset 08h reads the status byte and writes command, request and mode in their own byte lanes.
// [R10] Offset 0Ch reads the multichannel mask and a write to the clear lane performs a master clear.
// [R11] Byte lanes not applicable in a direction read as zero and ignore writes.
`timescale 1ns/1ps
module dma_slave_regs (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        acc_req,
	input  wire logic        acc_cfg,
	input  wire logic        acc_wr,
	input  wire logic [31:0] acc_addr,
	input  wire logic [3:0]  acc_be,
	input  wire logic [31:0] acc_wdata,
	input  wire logic        xfer_step,
	output logic             acc_ack,
	output logic             acc_hit,
	output logic [31:0]      acc_rdata,
	output logic [15:0]      cur_addr,
	output logic [7:0]       page,
	output logic [15:0]      cur_count,
	output logic [7:0]       command,
	output logic [7:0]       mode,
	output logic             request,
	output logic             masked,
	output logic             term_count
);
	logic [27:0] base_q;
	logic [15:0] base_addr_q, cur_addr_q, base_cnt_q, cur_cnt_q;
	logic [7:0]  page_q, cmd_q, mode_q;
	logic        req_q, mask_q, tc_q, ack_q, hit_q;
	logic [31:0] rdata_q, rdata_d;
	logic        cfg_sel, io_sel, wr_io, rd_io, step_ok, tc_hit;
	logic [3:0]  off;

	// Decode. The window stays closed while the base is zero so an unprogrammed part claims no I/O addresses.
	assign off     = acc_addr[3:0] & dma_slave_pkg::OFF_WORD_MASK;
	assign cfg_sel = acc_req && acc_cfg && (acc_addr[7:0] == dma_slave_pkg::CFG_BASE_OFF); // [R01]
	assign io_sel  = acc_req && !acc_cfg && (base_q != 28'h000_0000) &&
	                 (acc_addr[31:dma_slave_pkg::WIN_BITS] == base_q); // [R02]
	assign wr_io   = io_sel && acc_wr;
	assign rd_io   = io_sel && !acc_wr;
	assign step_ok = xfer_step && !mask_q && !cmd_q[dma_slave_pkg::CMD_DISABLE];
	// Terminal count is reached by a step taken while the count already reads zero.
	assign tc_hit  = step_ok && (cur_cnt_q == 16'h0000);

	// Window base register; only address bits above the 16-byte block are writable.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			base_q <= dma_slave_pkg::CFG_BASE_RST[31:4];
		end else if (cfg_sel && acc_wr) begin
			if (acc_be[0]) base_q[3:0]   <= acc_wdata[7:4]; // [R01]
			if (acc_be[1]) base_q[11:4]  <= acc_wdata[15:8];
			if (acc_be[2]) base_q[19:12] <= acc_wdata[23:16];
			if (acc_be[3]) base_q[27:20] <= acc_wdata[31:24];
		end
	end

	// Address, page and count. A register write beats a transfer step in the same cycle.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			base_addr_q <= dma_slave_pkg::WORD16_RST;
			cur_addr_q  <= dma_slave_pkg::WORD16_RST;
			base_cnt_q  <= dma_slave_pkg::WORD16_RST;
			cur_cnt_q   <= dma_slave_pkg::WORD16_RST;
			page_q      <= dma_slave_pkg::BYTE_RST;
		end else if (wr_io && off == dma_slave_pkg::OFF_ADDR) begin
			if (acc_be[0]) base_addr_q[7:0]  <= acc_wdata[7:0]; // [R07]
			if (acc_be[0]) cur_addr_q[7:0]   <= acc_wdata[7:0];
			if (acc_be[1]) base_addr_q[15:8] <= acc_wdata[15:8];
			if (acc_be[1]) cur_addr_q[15:8]  <= acc_wdata[15:8];
			if (acc_be[2]) page_q            <= acc_wdata[23:16];
		end else if (wr_io && off == dma_slave_pkg::OFF_COUNT) begin // [R06]
			if (acc_be[0]) base_cnt_q[7:0]  <= acc_wdata[7:0]; // [R08]
			if (acc_be[0]) cur_cnt_q[7:0]   <= acc_wdata[7:0];
			if (acc_be[1]) base_cnt_q[15:8] <= acc_wdata[15:8];
			if (acc_be[1]) cur_cnt_q[15:8]  <= acc_wdata[15:8];
		end else if (step_ok) begin
			if (cur_cnt_q == 16'h0000 && mode_q[dma_slave_pkg::MODE_AUTO]) begin
				cur_addr_q <= base_addr_q; // [R03]
				cur_cnt_q  <= base_cnt_q;
			end else begin
				cur_addr_q <= mode_q[dma_slave_pkg::MODE_DEC] ? cur_addr_q - 16'h0001 : cur_addr_q + 16'h0001;
				cur_cnt_q  <= cur_cnt_q - 16'h0001;
			end
		end
	end

	// Command, request and mode. Obsolete command bits are never stored.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_q  <= dma_slave_pkg::CMD_RST;
			mode_q <= dma_slave_pkg::MODE_RST;
			req_q  <= 1'b0;
		end else if (wr_io && off == dma_slave_pkg::OFF_MASK && acc_be[0]) begin
			cmd_q <= dma_slave_pkg::CMD_RST; // [R10]
			req_q <= 1'b0;
		end else if (wr_io && off == dma_slave_pkg::OFF_STAT) begin
			if (acc_be[0]) cmd_q  <= acc_wdata[7:0] & dma_slave_pkg::CMD_LIVE_MASK; // [R09] [R04]
			if (acc_be[1]) req_q  <= acc_wdata[8 + dma_slave_pkg::REQ_BIT];
			if (acc_be[3]) mode_q <= acc_wdata[31:24];
		end
	end

	// Mask and terminal count. A step reaching terminal count sets the flag even during a status read.
	// The hardware set also beats a software unmask in the same cycle, so a finished channel outside auto mode never runs on.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_q <= 1'b1;
			tc_q   <= 1'b0;
		end else begin
			if (tc_hit) begin
				tc_q <= 1'b1; // [R03]
			end else if ((rd_io && off == dma_slave_pkg::OFF_STAT) ||
			             (wr_io && off == dma_slave_pkg::OFF_MASK && acc_be[0])) begin
				tc_q <= 1'b0;
			end
			if (wr_io && off == dma_slave_pkg::OFF_MASK && acc_be[0]) begin
				mask_q <= 1'b1; // [R10]
			end else if (tc_hit && !mode_q[dma_slave_pkg::MODE_AUTO]) begin
				mask_q <= 1'b1; // [R03]
			end else if (wr_io && off == dma_slave_pkg::OFF_MASK && acc_be[3]) begin
				mask_q <= acc_wdata[24 + dma_slave_pkg::MASK_BIT];
			end
		end
	end

	// Read mux. Reserved and not-applicable lanes are tied to zero here.
	always_comb begin
		rdata_d = 32'h0000_0000; // [R05] [R11]
		if (cfg_sel) begin
			rdata_d = {base_q, dma_slave_pkg::CFG_BASE_RST[3:0]};
		end else if (rd_io && off == dma_slave_pkg::OFF_ADDR) begin
			rdata_d = {8'h00, page_q, cur_addr_q}; // [R07]
		end else if (rd_io && off == dma_slave_pkg::OFF_COUNT) begin
			rdata_d = {16'h0000, cur_cnt_q}; // [R08]
		end else if (rd_io && off == dma_slave_pkg::OFF_STAT) begin
			rdata_d[dma_slave_pkg::STAT_TC]  = tc_q; // [R09]
			rdata_d[dma_slave_pkg::STAT_REQ] = req_q;
		end else if (rd_io && off == dma_slave_pkg::OFF_MASK) begin
			rdata_d[24 + dma_slave_pkg::MASK_BIT] = mask_q; // [R10]
		end
	end

	// Answer one cycle after each request; writes answer with zero data.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_q   <= 1'b0;
			hit_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= acc_req;
			hit_q   <= cfg_sel || io_sel; // [R02]
			rdata_q <= acc_wr ? 32'h0000_0000 : rdata_d;
		end
	end

	assign acc_ack    = ack_q;
	assign acc_hit    = hit_q;
	assign acc_rdata  = rdata_q;
	assign cur_addr   = cur_addr_q;
	assign page       = page_q;
	assign cur_count  = cur_cnt_q;
	assign command    = cmd_q;
	assign mode       = mode_q;
	assign request    = req_q;
	assign masked     = mask_q;
	assign term_count = tc_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Checks on the register behaviour; each one guards one or two rules.
	base_write_load_a: assert property (cfg_sel && acc_wr && acc_be == 4'hF |=> base_q == $past(acc_wdata[31:4])) // [R01]
		else $error("window base not loaded");
	window_claim_a: assert property (io_sel |=> acc_hit && acc_ack) // [R02]
		else $error("window access not claimed");
	obsolete_cmd_a: assert property (cmd_q[1:0] == 2'b00) // [R04]
		else $error("obsolete command bits became set");
	addr_top_zero_a: assert property (rd_io && off == dma_slave_pkg::OFF_ADDR |=> acc_rdata[31:24] == 8'h00) // [R05]
		else $error("reserved address byte not zero");
	reserved_write_drop_a: assert property (wr_io && off == dma_slave_pkg::OFF_COUNT && acc_be == 4'hC // [R06]
		&& !step_ok |=> $stable(cur_cnt_q) && $stable(base_cnt_q))
		else $error("reserved lane write changed count");
	addr_lane_drop_a: assert property (wr_io && off == dma_slave_pkg::OFF_ADDR && acc_be == 4'h8 && !step_ok // [R06]
		|=> $stable(cur_addr_q) && $stable(base_addr_q) && $stable(page_q))
		else $error("reserved address lane write changed state");
	addr_load_a: assert property (wr_io && off == dma_slave_pkg::OFF_ADDR && acc_be[1:0] == 2'b11 // [R07]
		|=> cur_addr == $past(acc_wdata[15:0]))
		else $error("base address write not loaded");
	count_load_a: assert property (wr_io && off == dma_slave_pkg::OFF_COUNT && acc_be[1:0] == 2'b11 // [R08]
		|=> cur_count == $past(acc_wdata[15:0]) && acc_rdata == 32'h0000_0000)
		else $error("base count write not loaded");
	status_read_a: assert property (rd_io && off == dma_slave_pkg::OFF_STAT // [R09] [R11]
		|=> acc_rdata[dma_slave_pkg::STAT_REQ] == $past(req_q) && acc_rdata[31:8] == 24'h00_0000)
		else $error("status read mismatch");
	mask_read_zero_a: assert property (rd_io && off == dma_slave_pkg::OFF_MASK // [R11]
		|=> acc_rdata[23:0] == 24'h00_0000 && acc_rdata[31:25] == 7'h00)
		else $error("unused mask lanes not zero");
	master_clear_a: assert property (wr_io && off == dma_slave_pkg::OFF_MASK && acc_be[0] // [R10]
		|=> masked && command == 8'h00 && !request && term_count == $past(tc_hit))
		else $error("master clear incomplete");
	tc_mask_a: assert property (tc_hit && !mode_q[dma_slave_pkg::MODE_AUTO] && !acc_req // [R03]
		|=> term_count && masked)
		else $error("terminal count did not mask channel");

	// Main scenarios that the bench is expected to reach.
	cover_master_clear_c: cover property (wr_io && off == dma_slave_pkg::OFF_MASK && acc_be[0]);
	cover_reserved_write_c: cover property (wr_io && off == dma_slave_pkg::OFF_COUNT && acc_be == 4'hC);
	cover_tc_reached_c: cover property (step_ok && cur_cnt_q == 16'h0000);
	cover_status_read_c: cover property (rd_io && off == dma_slave_pkg::OFF_STAT ##1 acc_ack);
endmodule : dma_slave_regs

// ### tb/distributed_dma_slave_regs_tb_top.sv
// Self-checking bench for the distributed DMA slave register block.
`timescale 1ns/1ps
module distributed_dma_slave_regs_tb_top;
	logic        clk, resetn, xfer_step, acc_req, acc_cfg, acc_wr, acc_ack, acc_hit, request, masked, term_count;
	logic [31:0] acc_addr, acc_wdata, acc_rdata, seed, rd, wd;
	logic [15:0] cur_addr, cur_count;
	logic [7:0]  page, command, mode;
	logic [3:0]  acc_be;
	logic [1:0]  st;
	int          bad_count, n_compared;
	dma_slave_regs u_dma_slave_regs (.clk(clk), .resetn(resetn), .acc_req(acc_req), .acc_cfg(acc_cfg),
		.acc_wr(acc_wr), .acc_addr(acc_addr), .acc_be(acc_be), .acc_wdata(acc_wdata), .xfer_step(xfer_step),
		.acc_ack(acc_ack), .acc_hit(acc_hit), .acc_rdata(acc_rdata), .cur_addr(cur_addr), .page(page),
		.cur_count(cur_count), .command(command), .mode(mode), .request(request), .masked(masked),
		.term_count(term_count));
	host_model u_host_model (.clk(clk), .acc_ack(acc_ack), .acc_hit(acc_hit), .acc_rdata(acc_rdata),
		.acc_req(acc_req), .acc_cfg(acc_cfg), .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_be(acc_be),
		.acc_wdata(acc_wdata));
	// Xorshift keeps the random stream repeatable from the fixed seed.
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected read-back: the reserved top lanes must come back as zero.
	function automatic logic [31:0] exp_addr(input logic [31:0] d);
		return {8'h00, d[23:0]};
	endfunction
	function automatic logic [31:0] exp_count(input logic [31:0] d);
		return {16'h0000, d[15:0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Window accesses take the full I/O address; the task adds no base of its own.
	task automatic io(input logic wr, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
		u_host_model.xfer(1'b0, wr, a, be, d, rd, st);
	endtask
	task automatic step();
		@(posedge clk);
		xfer_step <= 1'b1;
		@(posedge clk);
		xfer_step <= 1'b0;
		@(posedge clk);
	endtask
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// The tests need well under a thousand cycles; twenty thousand means a hang.
	initial begin
		#2_000_000;
		bad_count++;
		end_of_test();
	end
	initial begin
		resetn = 1'b0;
		xfer_step = 1'b0;
		bad_count = 0;
		n_compared = 0;
		seed = 32'h0000_94EE;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		chk("reset state", {cur_addr, cur_count}, 32'h0000_0000);
		chk("reset mask", {31'h0000_0000, masked}, 32'h0000_0001);
		u_host_model.xfer(1'b1, 1'b0, 32'h0000_0098, 4'hF, 32'h0000_0000, rd, st);
		chk("base reset", rd, 32'h0000_0001);
		io(1'b0, 32'h0000_1008, 4'hF, 32'h0000_0000);
		chk("closed window", {30'h0000_0000, st}, 32'h0000_0002);
		u_host_model.xfer(1'b1, 1'b1, 32'h0000_0098, 4'hF, 32'h0000_1000, rd, st);
		u_host_model.xfer(1'b1, 1'b0, 32'h0000_0098, 4'hF, 32'h0000_0000, rd, st);
		chk("base readback", rd, 32'h0000_1001);
		u_host_model.xfer(1'b1, 1'b0, 32'h0000_009C, 4'hF, 32'h0000_0000, rd, st);
		chk("unmapped cfg", {st, rd[29:0]}, 32'h8000_0000);
		io(1'b0, 32'h0000_1010, 4'hF, 32'h0000_0000);
		chk("above window", {30'h0000_0000, st}, 32'h0000_0002);
		io(1'b0, 32'h0000_100C, 4'hF, 32'h0000_0000);
		chk("mask read", rd, 32'h0100_0000);
		$display("test decode done");
		repeat (8) begin
			wd = xs();
			io(1'b1, 32'h0000_1000, 4'hF, wd);
			io(1'b0, 32'h0000_1000, 4'hF, 32'h0000_0000);
			chk("address read", rd, exp_addr(wd));
			chk("address out", {8'h00, page, cur_addr}, exp_addr(wd));
			io(1'b1, 32'h0000_1000, 4'h8, ~wd);
			chk("address top lane", {8'h00, page, cur_addr}, exp_addr(wd));
			wd = xs();
			io(1'b1, 32'h0000_1004, 4'hF, wd);
			io(1'b0, 32'h0000_1004, 4'hF, 32'h0000_0000);
			chk("count read", rd, exp_count(wd));
			io(1'b1, 32'h0000_1004, 4'hC, ~wd);
			io(1'b0, 32'h0000_1004, 4'hF, 32'h0000_0000);
			chk("count upper lanes", rd, exp_count(wd));
		end
		$display("test random load done");
		io(1'b1, 32'h0000_1008, 4'hF, 32'h1055_04FF);
		chk("cmd mode", {16'h0000, mode, command}, 32'h0000_10FC);
		io(1'b0, 32'h0000_1008, 4'hF, 32'h0000_0000);
		chk("status", rd, 32'h0000_0010);
		io(1'b1, 32'h0000_100C, 4'h1, 32'h0000_0000);
		chk("master clear", {16'h0000, command, 6'h00, request, masked}, 32'h0000_0001);
		io(1'b1, 32'h0000_100C, 4'h8, 32'h0000_0000);
		chk("unmask", {31'h0000_0000, masked}, 32'h0000_0000);
		$display("test command done");
		io(1'b1, 32'h0000_1008, 4'h8, 32'h0000_0000);
		io(1'b1, 32'h0000_1000, 4'h3, 32'h0000_0010);
		io(1'b1, 32'h0000_1004, 4'h3, 32'h0000_0001);
		step();
		chk("one step", {cur_addr, cur_count}, 32'h0011_0000);
		step();
		chk("terminal", {30'h0000_0000, term_count, masked}, 32'h0000_0003);
		io(1'b0, 32'h0000_1008, 4'hF, 32'h0000_0000);
		chk("tc status", rd, 32'h0000_0001);
		io(1'b0, 32'h0000_1008, 4'hF, 32'h0000_0000);
		chk("tc cleared", rd, 32'h0000_0000);
		$display("test transfer done");
		end_of_test();
	end
endmodule // distributed_dma_slave_regs_tb_top

// ### tb/host_model.sv
// Host-side model that issues configuration and I/O accesses to the DMA registers.
`timescale 1ns/1ps
module host_model (
	input  wire logic        clk,
	input  wire logic        acc_ack,
	input  wire logic        acc_hit,
	input  wire logic [31:0] acc_rdata,
	output logic             acc_req,
	output logic             acc_cfg,
	output logic             acc_wr,
	output logic [31:0]      acc_addr,
	output logic [3:0]       acc_be,
	output logic [31:0]      acc_wdata
);
	// Lines start quiet; no request may come before reset is released.
	initial begin
		acc_req = 1'b0;
		acc_cfg = 1'b0;
		acc_wr = 1'b0;
		acc_addr = 32'h0000_0000;
		acc_be = 4'h0;
		acc_wdata = 32'h0000_0000;
	end
	// One request pulse, then the answer is taken one cycle later.
	// Released address and data lines carry the inverse so stale values never look valid.
	task automatic xfer(input logic cfg, input logic wr, input logic [31:0] addr, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd, output logic [1:0] st);
		@(posedge clk);
		acc_req <= 1'b1;
		acc_cfg <= cfg;
		acc_wr <= wr;
		acc_addr <= addr;
		acc_be <= be;
		acc_wdata <= wd;
		@(posedge clk);
		acc_req <= 1'b0;
		acc_addr <= ~addr;
		acc_wdata <= ~wd;
		@(posedge clk);
		rd = acc_rdata;
		st = {acc_ack, acc_hit};
	endtask
endmodule // host_model
